/* File: shared/pmic_regs_pkg.sv */
`default_nettype none

package pmic_regs_pkg;

    // ------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------
    localparam logic [6:0] BUS_ADDRESS = 7'h60;   // Seven-bit device address
    localparam logic [3:0] BYTE_BITS = 4'h8;      // Bits in one byte
    localparam logic [3:0] FIRST_BIT_SENT = 4'h1; // Count after the MSB is out
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0; // Empty bit counter
    localparam logic [3:0] BIT_STEP = 4'h1;       // Bit counter step
    localparam logic [7:0] INDEX_STEP = 8'h01;    // Register index step on writes
    localparam int RW_BIT = 0;                    // Direction bit in address byte
    localparam int MSB_BIT = 7;                   // Top bit of a byte
    localparam int NEXT_BIT = 6;                  // Bit that follows the MSB

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_COUNT = 39;                // Indices 0x00 to 0x26
    localparam logic [7:0] ADDR_DEVICE_REVISION_ID = 8'h00;
    localparam logic [7:0] ADDR_NVM_VERSION_ID = 8'h01;
    localparam logic [7:0] ADDR_BUCK_A_CONTROL_ONE = 8'h02;
    localparam logic [7:0] ADDR_EXT_CLOCK_SYNC_CONFIG = 8'h14;
    localparam logic [7:0] ADDR_POWER_GOOD_CONFIG_A = 8'h15;
    localparam logic [7:0] ADDR_POWER_GOOD_CONFIG_B = 8'h16;
    localparam logic [7:0] ADDR_POWER_GOOD_FAULT_STATUS = 8'h17;
    localparam logic [7:0] ADDR_SOFTWARE_RESET_CTRL = 8'h18;
    localparam logic [7:0] ADDR_INTERRUPT_TOP_A = 8'h19;
    localparam logic [7:0] ADDR_INTERRUPT_TOP_B = 8'h1A;
    localparam logic [7:0] ADDR_INTERRUPT_BUCK_FLAGS = 8'h1B;
    localparam logic [7:0] ADDR_INTERRUPT_LINEAR_FLAGS = 8'h1C;
    localparam logic [7:0] ADDR_TOP_STATUS_FLAGS = 8'h1D;
    localparam logic [7:0] ADDR_BUCK_STATUS_FLAGS = 8'h1E;
    localparam logic [7:0] ADDR_LINEAR_STATUS_FLAGS = 8'h1F;
    localparam logic [7:0] ADDR_TOP_INTERRUPT_MASK_A = 8'h20;
    localparam logic [7:0] ADDR_TOP_INTERRUPT_MASK_B = 8'h21;
    localparam logic [7:0] ADDR_BUCK_INTERRUPT_MASK = 8'h22;
    localparam logic [7:0] ADDR_LINEAR_INTERRUPT_MASK = 8'h23;
    localparam logic [7:0] ADDR_LOAD_CURRENT_SELECT = 8'h24;
    localparam logic [7:0] ADDR_LOAD_CURRENT_HIGH = 8'h25;
    localparam logic [7:0] ADDR_LOAD_CURRENT_LOW = 8'h26;
    localparam int FLAG_REG_COUNT = 4;            // Interrupt flag registers

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int BUCK_A_FORCED_PWM_BIT = 3;
    localparam int BUCK_A_DISCHARGE_ENABLE_BIT = 2;
    localparam int BUCK_A_PIN_GATING_BIT = 1;
    localparam int BUCK_A_ENABLE_BIT = 0;
    localparam logic [7:0] BUCK_A_CONTROL_ONE_RESET = 8'h0F;
    localparam logic [7:0] SOFTWARE_RESET_MASK = 8'h01;  // Self-clearing bit
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [5:0] REVISION_LOW_BITS = 6'h02;    // Fixed bits 5:0
    localparam logic [6:0] LOAD_HIGH_PAD = 7'h00;        // Upper bits of high byte
    localparam int LOAD_CURRENT_W = 9;                   // Load readout width

    // ------------------------------------------------------------
    // Serial engine states
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,        // Not addressed, waiting for start
        ST_ADDR = 9'h002,        // Shifting in address byte
        ST_ADDR_ACK = 9'h004,    // Driving acknowledge of address
        ST_REG = 9'h008,         // Shifting in register index
        ST_REG_ACK = 9'h010,     // Driving acknowledge of index
        ST_WDATA = 9'h020,       // Shifting in a data byte
        ST_WDATA_ACK = 9'h040,   // Driving acknowledge of data
        ST_RDATA = 9'h080,       // Shifting out a data byte
        ST_RACK = 9'h100         // Sampling acknowledge from host
    } engine_state_type;

endpackage

`default_nettype wire

/* File: shared/line_events_if.sv */
`timescale 1ns/1ns
`default_nettype none

// Pin events seen on the serial lines, passed to the engine
interface line_events_if;
    logic scl_rise; // SCL went high, one-cycle pulse
    logic scl_fall; // SCL went low, one-cycle pulse
    logic start;    // Start or repeated start, one-cycle pulse
    logic stop;     // Stop condition, one-cycle pulse
    logic sda_bit;  // SDA level sampled with the pins

    modport watcher (output scl_rise, output scl_fall, output start, output stop,
        output sda_bit);
    modport engine (input scl_rise, input scl_fall, input start, input stop,
        input sda_bit);
endinterface

`default_nettype wire

/* File: logic/line_watch.sv */
`timescale 1ns/1ns
`default_nettype none

module line_watch (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    line_events_if.watcher events
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl_q;    // SCL one cycle ago
        logic sda_q;    // SDA one cycle ago
        logic scl_rise; // Rising clock edge seen
        logic scl_fall; // Falling clock edge seen
        logic start;    // Data fell while clock high
        logic stop;     // Data rose while clock high
        logic sda_bit;  // Registered data level
    } watch_type;

    localparam watch_type WATCH_INIT = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    watch_type s_r;
    watch_type s_nxt;

    // Edge and condition detection on the sampled pins
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.scl_q = scl_in;
        s_nxt.sda_q = sda_in;
        s_nxt.scl_rise = scl_in & ~s_r.scl_q;
        s_nxt.scl_fall = ~scl_in & s_r.scl_q;
        s_nxt.start = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
        s_nxt.stop = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;
        s_nxt.sda_bit = sda_in;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= WATCH_INIT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign events.scl_rise = s_r.scl_rise;
    assign events.scl_fall = s_r.scl_fall;
    assign events.start = s_r.start;
    assign events.stop = s_r.stop;
    assign events.sda_bit = s_r.sda_bit;

endmodule // line_watch

`default_nettype wire

/* File: logic/pmic_control_register_bank.sv */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Bit 3 forces PWM, else automatic mode
// - Bit 2 connects discharge while converter off
// - Bit 1 adds external pin to enable
// - Bit 0 enables converter, gated as selected
// - Address zero bits 7:6 read-only ID
// - Address one reads read-only memory version
// - Address byte, direction, index, then data
// - Writes auto-increment index; reads do not
// - Respond only at bus address 0x60
module pmic_control_register_bank #(
    parameter logic [1:0] PART_ID_CODE = 2'h1,        // Arbitrary value
    parameter logic [7:0] NVM_VERSION_CODE = 8'h5A    // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    input wire logic buck_a_en_pin,
    input wire logic [7:0] power_good_fault_status_in,
    input wire logic [7:0] top_status_in,
    input wire logic [7:0] buck_status_in,
    input wire logic [7:0] linear_status_in,
    input wire logic [pmic_regs_pkg::LOAD_CURRENT_W-1:0] load_current_in,
    input wire logic [7:0] top_a_event_in,
    input wire logic [7:0] top_b_event_in,
    input wire logic [7:0] buck_event_in,
    input wire logic [7:0] linear_event_in,
    output logic buck_a_forced_pwm,
    output logic buck_a_discharge_on,
    output logic buck_a_active,
    output logic sw_reset_pulse
);
    import pmic_regs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef logic [REG_COUNT-1:0][7:0] bank_type;

    typedef struct packed {
        engine_state_type state;   // Serial engine state
        logic [3:0] bit_count;     // Bits moved in current byte
        logic [7:0] shift;         // Byte being shifted
        logic [7:0] index;         // Internal register index
        logic read_dir;            // Transfer is a read
        logic drive_n;             // Low while pulling SDA low
        logic sda_level;           // Level put on SDA when driven
        bank_type regfile;         // Stored register contents
        logic forced_pwm;          // Converter mode output
        logic discharge_on;        // Discharge resistor output
        logic active;              // Converter enable output
        logic sw_reset;            // Software reset pulse
    } engine_type;

    // Power-on contents of the stored registers
    function automatic bank_type bank_defaults();
        bank_type b;
        b = '0;
        b[ADDR_BUCK_A_CONTROL_ONE] = BUCK_A_CONTROL_ONE_RESET;
        return b;
    endfunction

    localparam engine_type ENGINE_INIT = '{
        state: ST_IDLE,
        bit_count: BIT_COUNT_ZERO,
        shift: BYTE_ZERO,
        index: BYTE_ZERO,
        read_dir: 1'b0,
        drive_n: 1'b1,
        sda_level: 1'b0,
        regfile: bank_defaults(),
        forced_pwm: BUCK_A_CONTROL_ONE_RESET[BUCK_A_FORCED_PWM_BIT],
        discharge_on: 1'b0,
        active: 1'b0,
        sw_reset: 1'b0
    };

    engine_type s_r;
    engine_type s_nxt;

    line_events_if line_ev ();

    // ------------------------------------------------------------
    // Pin watcher
    // ------------------------------------------------------------
    line_watch u_line_watch (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .events(line_ev)
    );

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    // Byte returned for a register index; unmapped indices read zero
    function automatic logic [7:0] read_byte(input logic [7:0] idx, input bank_type b);
        logic [7:0] v;
        v = BYTE_ZERO;
        unique case (idx)
            // Identification code, writes never reach it
            ADDR_DEVICE_REVISION_ID: v = {PART_ID_CODE, REVISION_LOW_BITS};
            // Memory version code, read-only
            ADDR_NVM_VERSION_ID: v = NVM_VERSION_CODE;
            ADDR_POWER_GOOD_FAULT_STATUS: v = power_good_fault_status_in;
            ADDR_TOP_STATUS_FLAGS: v = top_status_in;
            ADDR_BUCK_STATUS_FLAGS: v = buck_status_in;
            ADDR_LINEAR_STATUS_FLAGS: v = linear_status_in;
            ADDR_LOAD_CURRENT_HIGH:
                v = {LOAD_HIGH_PAD, load_current_in[LOAD_CURRENT_W-1]};
            ADDR_LOAD_CURRENT_LOW: v = load_current_in[7:0];
            ADDR_BUCK_A_CONTROL_ONE, ADDR_EXT_CLOCK_SYNC_CONFIG,
            ADDR_POWER_GOOD_CONFIG_A, ADDR_POWER_GOOD_CONFIG_B,
            ADDR_SOFTWARE_RESET_CTRL, ADDR_INTERRUPT_TOP_A,
            ADDR_INTERRUPT_TOP_B, ADDR_INTERRUPT_BUCK_FLAGS,
            ADDR_INTERRUPT_LINEAR_FLAGS, ADDR_TOP_INTERRUPT_MASK_A,
            ADDR_TOP_INTERRUPT_MASK_B, ADDR_BUCK_INTERRUPT_MASK,
            ADDR_LINEAR_INTERRUPT_MASK, ADDR_LOAD_CURRENT_SELECT:
                v = b[idx];
            default: v = BYTE_ZERO;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Serial engine and register bank
    // ------------------------------------------------------------
    // Byte framing, acknowledge, register writes, flags and outputs
    always_comb
    begin
        logic [FLAG_REG_COUNT-1:0][7:0] events;  // Flag set sources
        logic [FLAG_REG_COUNT-1:0][7:0] clears;  // Flag clear requests
        logic [7:0] rd;                          // Byte to send
        logic [7:0] wd;                          // Byte received
        logic bank_reset;                        // Software reset request
        logic [7:0] ctrl;                        // Converter control byte
        events = {linear_event_in, buck_event_in, top_b_event_in, top_a_event_in};
        clears = '0;
        rd = read_byte(s_r.index, s_r.regfile);
        wd = s_r.shift;
        bank_reset = 1'b0;
        ctrl = BYTE_ZERO;
        s_nxt = s_r;
        s_nxt.sw_reset = 1'b0;
        s_nxt.sda_level = 1'b0;

        if (line_ev.stop)
        begin
            // Stop ends any transfer and frees the line
            s_nxt.state = ST_IDLE;
            s_nxt.drive_n = 1'b1;
        end
        else if (line_ev.start)
        begin
            // Start or repeated start begins a new address byte
            s_nxt.state = ST_ADDR;
            s_nxt.bit_count = BIT_COUNT_ZERO;
            s_nxt.drive_n = 1'b1;
        end
        else
        begin
            unique case (s_r.state)
                ST_IDLE:
                begin
                    // Nothing to do until a start
                    s_nxt.drive_n = 1'b1;
                end
                ST_ADDR, ST_REG, ST_WDATA:
                begin
                    if (line_ev.scl_rise && s_r.bit_count != BYTE_BITS)
                    begin
                        // Shift in the bit, MSB first
                        s_nxt.shift = {s_r.shift[NEXT_BIT:0], line_ev.sda_bit};
                        s_nxt.bit_count = s_r.bit_count + BIT_STEP;
                    end
                    else if (line_ev.scl_fall && s_r.bit_count == BYTE_BITS)
                    begin
                        if (s_r.state == ST_ADDR)
                        begin
                            if (wd[MSB_BIT:1] == BUS_ADDRESS)
                            begin
                                // Own address: remember direction and acknowledge
                                s_nxt.read_dir = wd[RW_BIT];
                                s_nxt.drive_n = 1'b0;
                                s_nxt.state = ST_ADDR_ACK;
                            end
                            else
                            begin
                                // Another device: stay off the line
                                s_nxt.state = ST_IDLE;
                            end
                        end
                        else if (s_r.state == ST_REG)
                        begin
                            // Second byte selects the register
                            s_nxt.index = wd;
                            s_nxt.drive_n = 1'b0;
                            s_nxt.state = ST_REG_ACK;
                        end
                        else
                        begin
                            // Data byte: store, then step to the next register
                            unique case (s_r.index)
                                ADDR_BUCK_A_CONTROL_ONE, ADDR_EXT_CLOCK_SYNC_CONFIG,
                                ADDR_POWER_GOOD_CONFIG_A, ADDR_POWER_GOOD_CONFIG_B,
                                ADDR_TOP_INTERRUPT_MASK_A, ADDR_TOP_INTERRUPT_MASK_B,
                                ADDR_BUCK_INTERRUPT_MASK, ADDR_LINEAR_INTERRUPT_MASK,
                                ADDR_LOAD_CURRENT_SELECT:
                                    s_nxt.regfile[s_r.index] = wd;
                                ADDR_SOFTWARE_RESET_CTRL:
                                begin
                                    // Reset bit acts once and reads back zero
                                    s_nxt.regfile[s_r.index] = wd & ~SOFTWARE_RESET_MASK;
                                    bank_reset = |(wd & SOFTWARE_RESET_MASK);
                                end
                                ADDR_INTERRUPT_TOP_A, ADDR_INTERRUPT_TOP_B,
                                ADDR_INTERRUPT_BUCK_FLAGS, ADDR_INTERRUPT_LINEAR_FLAGS:
                                    // Writing one clears a flag
                                    clears[s_r.index - ADDR_INTERRUPT_TOP_A] = wd;
                                default:
                                    // Read-only or unmapped: write ignored
                                    bank_reset = 1'b0;
                            endcase
                            s_nxt.index = s_r.index + INDEX_STEP;
                            s_nxt.drive_n = 1'b0;
                            s_nxt.state = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (line_ev.scl_fall)
                    begin
                        if (s_r.read_dir)
                        begin
                            // Read: put the MSB of the selected register out
                            s_nxt.shift = rd;
                            s_nxt.drive_n = rd[MSB_BIT];
                            s_nxt.bit_count = FIRST_BIT_SENT;
                            s_nxt.state = ST_RDATA;
                        end
                        else
                        begin
                            // Write: register index follows
                            s_nxt.drive_n = 1'b1;
                            s_nxt.bit_count = BIT_COUNT_ZERO;
                            s_nxt.state = ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK:
                begin
                    if (line_ev.scl_fall)
                    begin
                        // Release and take the next data byte
                        s_nxt.drive_n = 1'b1;
                        s_nxt.bit_count = BIT_COUNT_ZERO;
                        s_nxt.state = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (line_ev.scl_fall)
                    begin
                        if (s_r.bit_count == BYTE_BITS)
                        begin
                            // Byte done: free the line for the host acknowledge
                            s_nxt.drive_n = 1'b1;
                            s_nxt.state = ST_RACK;
                        end
                        else
                        begin
                            // Next bit; a one releases the line
                            s_nxt.drive_n = s_r.shift[NEXT_BIT];
                            s_nxt.shift = {s_r.shift[NEXT_BIT:0], 1'b0};
                            s_nxt.bit_count = s_r.bit_count + BIT_STEP;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (line_ev.scl_rise)
                    begin
                        if (line_ev.sda_bit)
                        begin
                            // Host declined more data
                            s_nxt.state = ST_IDLE;
                        end
                        else
                        begin
                            // More wanted: same register again, index kept
                            s_nxt.state = ST_ADDR_ACK;
                        end
                    end
                end
            endcase
        end

        // Software reset restores stored registers and clears flags
        if (bank_reset)
        begin
            s_nxt.regfile = bank_defaults();
            s_nxt.sw_reset = 1'b1;
            clears = {FLAG_REG_COUNT{BYTE_ONES}};
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        for (int i = 0; i < FLAG_REG_COUNT; i++)
        begin
            s_nxt.regfile[int'(ADDR_INTERRUPT_TOP_A) + i] =
                (s_r.regfile[int'(ADDR_INTERRUPT_TOP_A) + i] & ~clears[i]) | events[i];
        end

        // Converter controls from the stored control byte
        ctrl = s_nxt.regfile[ADDR_BUCK_A_CONTROL_ONE];
        s_nxt.forced_pwm = ctrl[BUCK_A_FORCED_PWM_BIT];
        s_nxt.active = ctrl[BUCK_A_ENABLE_BIT]
            & (~ctrl[BUCK_A_PIN_GATING_BIT] | buck_a_en_pin);
        s_nxt.discharge_on = ctrl[BUCK_A_DISCHARGE_ENABLE_BIT] & ~s_nxt.active;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= ENGINE_INIT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out = s_r.sda_level;
    assign sda_drive_n = s_r.drive_n;
    assign buck_a_forced_pwm = s_r.forced_pwm;
    assign buck_a_discharge_on = s_r.discharge_on;
    assign buck_a_active = s_r.active;
    assign sw_reset_pulse = s_r.sw_reset;

endmodule // pmic_control_register_bank

`default_nettype wire

/* File: bench/pmic_bank_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the bank outputs
module pmic_bank_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic buck_a_en_pin,
    input wire logic sda_out,
    input wire logic sda_drive_n,
    input wire logic buck_a_forced_pwm,
    input wire logic buck_a_discharge_on,
    input wire logic buck_a_active,
    input wire logic sw_reset_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_rst; $rose(resetn) |-> sda_drive_n && buck_a_forced_pwm && !sw_reset_pulse; endproperty
    a_rst: assert property (p_rst) else $error("bad state at reset release");
    property p_pwm; $changed(buck_a_forced_pwm) && $past(resetn, 2) |-> !$past(scl_in, 2); endproperty
    a_pwm: assert property (p_pwm) else $error("mode changed outside a write");
    property p_act; $changed(buck_a_active) && $past(resetn, 2) && !sw_reset_pulse
        |-> !$past(scl_in, 2) || $past(buck_a_en_pin) != $past(buck_a_en_pin, 2); endproperty
    a_act: assert property (p_act) else $error("enable changed without cause");
    property p_dis; buck_a_active && $past(buck_a_active) |-> !buck_a_discharge_on; endproperty
    a_dis: assert property (p_dis) else $error("discharge while running");
    property p_od; !sda_drive_n |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_drv; $changed(sda_drive_n) && $past(resetn, 2) |-> !$past(scl_in, 2); endproperty
    a_drv: assert property (p_drv) else $error("data drive moved with clock high");
    property p_ack; $fell(sda_drive_n) |=> !sda_drive_n [*4]; endproperty
    a_ack: assert property (p_ack) else $error("acknowledge too short");
    property p_swr; sw_reset_pulse |-> ##[0:3] buck_a_forced_pwm; endproperty
    a_swr: assert property (p_swr) else $error("soft reset left mode unset");
endmodule // pmic_bank_monitor
`default_nettype wire

/* File: bench/i2c_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Serial host; clock low for five cycles, high for four
module i2c_host_model (
    input wire logic clk_sys,
    input wire logic sda_in,
    output logic scl,
    output logic sda_hold_n
);
    initial scl = 1'b1;
    initial sda_hold_n = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One bit: data moves a cycle after the fall, wire sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        tick(1);
        sda_hold_n <= b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        r = sda_in;
        tick(2);
        scl <= 1'b0;
    endtask
    // Byte MSB first, acknowledge slot in bit 0
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_x(d[i], q[i]);
    endtask
    task automatic start;
        tick(1);
        sda_hold_n <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_hold_n <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop;
        tick(1);
        sda_hold_n <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_hold_n <= 1'b1;
        tick(4);
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: bench/pmic_control_register_bank_test.sv */
`timescale 1ns/1ns
`default_nettype none
module pmic_control_register_bank_test;
    localparam logic [1:0] ID = 2'h2; // Arbitrary value
    localparam logic [7:0] NVM = 8'hA5; // Arbitrary value
    logic clk_sys, resetn, pin, scl, hold_n, sda_out, drive_n, pwm, dis, act, swr;
    logic [7:0] st, v;
    logic [8:0] q;
    int failures = 0, n_checks = 0;
    wire logic sda_w = hold_n & (drive_n | sda_out);
    // Rows: index, data, readback, pin nibble, mode/active/discharge nibble
    logic [31:0] rows [9] = '{32'h00C2_8216, 32'h0100_A516, 32'h1705_3C16, 32'h1077_0016,
        32'h020F_0F05, 32'h020D_0D06, 32'h0204_0401, 32'h0208_0814, 32'h145A_5A14};
    pmic_control_register_bank #(.PART_ID_CODE(ID), .NVM_VERSION_CODE(NVM)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_drive_n(drive_n), .buck_a_en_pin(pin), .power_good_fault_status_in(st), .top_status_in(st),
        .buck_status_in(st), .linear_status_in(st), .load_current_in({1'b0, st}),
        .top_a_event_in(st), .top_b_event_in(st), .buck_event_in(st), .linear_event_in(st),
        .buck_a_forced_pwm(pwm), .buck_a_discharge_on(dis), .buck_a_active(act),
        .sw_reset_pulse(swr));
    i2c_host_model h (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda_hold_n(hold_n));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", s, exp, seen);
            failures++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic two);
        h.start();
        h.xfer({8'hC0, 1'b1}, q);
        chk("address ack", {7'h00, q[0]}, 8'h00);
        h.xfer({a, 1'b1}, q);
        h.xfer({d[15:8], 1'b1}, q);
        if (two) h.xfer({d[7:0], 1'b1}, q);
        h.stop();
    endtask
    // Read bytes in a row all come from one index
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        h.start();
        h.xfer({8'hC0, 1'b1}, q);
        h.xfer({a, 1'b1}, q);
        h.start();
        h.xfer({8'hC1, 1'b1}, q);
        h.xfer(9'h1FE, q);
        r = q[8:1];
        h.xfer(9'h1FF, q);
        chk("repeat read", q[8:1], r);
        h.stop();
    endtask
    task automatic give_verdict;
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        resetn = 1'b0;
        pin = 1'b1;
        st = 8'h3C;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("reset outputs", {5'h00, pwm, act, dis}, 8'h06);
        rd(8'h02, v);
        chk("reset control", v, 8'h0F);
        foreach (rows[i])
        begin
            pin <= rows[i][4];
            wr(rows[i][31:24], {rows[i][23:16], 8'h00}, 1'b0);
            rd(rows[i][31:24], v);
            chk("row data", v, rows[i][15:8]);
            chk("row outputs", {5'h00, pwm, act, dis}, {5'h00, rows[i][2:0]});
        end
        // Two data bytes land in consecutive registers
        wr(8'h20, 16'h1101, 1'b1);
        rd(8'h21, v);
        chk("increment", v, 8'h01);
        // Foreign bus address: no acknowledge
        h.start();
        h.xfer({8'hC2, 1'b1}, q);
        h.stop();
        chk("foreign ack", {7'h00, q[0]}, 8'h01);
        // Soft reset, then a mid-run hard reset, restore control defaults
        wr(8'h18, 16'h0100, 1'b0);
        rd(8'h02, v);
        chk("soft reset", v, 8'h0F);
        wr(8'h02, 16'h0000, 1'b0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("second reset", {5'h00, pwm, act, dis}, 8'h06);
        give_verdict();
    end
endmodule // pmic_control_register_bank_test
bind pmic_control_register_bank pmic_bank_monitor mon (.clk_sys(clk_sys), .resetn(resetn),
    .scl_in(scl_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n), .buck_a_en_pin(buck_a_en_pin),
    .buck_a_forced_pwm(buck_a_forced_pwm), .buck_a_discharge_on(buck_a_discharge_on),
    .buck_a_active(buck_a_active), .sw_reset_pulse(sw_reset_pulse));
`default_nettype wire
